// >>> include/lbm_map.svh
// Register map, field positions, reset values and timing of the activity monitor
`ifndef LBM_MAP_SVH
`define LBM_MAP_SVH

`define LBM_ADDR_UPPER 8'h5C
`define LBM_ADDR_LOWER 8'h5D
`define LBM_ADDR_SIZE 8'h5E
`define LBM_ADDR_DECAY 8'h5F
`define LBM_ADDR_IRQ_STAT 8'h60
`define LBM_ADDR_IRQ_MASK 8'h61
`define LBM_ADDR_LEVEL 8'h62
`define LBM_ADDR_FLAGS 8'h63

`define LBM_RST_UPPER 8'h06
`define LBM_RST_LOWER 8'h04
`define LBM_RST_SIZE 8'h08
`define LBM_RST_DECAY 2'h1
`define LBM_RST_MASK 2'h0

`define LBM_IRQ_RAISE 0
`define LBM_IRQ_CLEAR 1
`define LBM_FLAG_ALARM 0
`define LBM_FLAG_BAD 1

`define LBM_CLK_KHZ 25000
`define LBM_FILL_MS 128
`define LBM_FILL_CYC (`LBM_FILL_MS * `LBM_CLK_KHZ)

`endif

// >>> include/lbm_pkg.sv
// Types shared by the activity monitor and its timebase
`default_nettype none
package lbm_pkg;

  typedef enum logic [0:0] {
    ALARM_IDLE = 1'b0,
    ALARM_RAISED = 1'b1
  } alarm_state_t;

  typedef struct packed {
    logic fail_s1;
    logic fail_s2;
    logic err_s1;
    logic err_s2;
    logic bad_seen;
    logic [7:0] acc;
    logic [2:0] clean;
    alarm_state_t alarm;
    logic [7:0] size;
    logic [7:0] lower;
    logic [7:0] upper;
    logic [1:0] rate;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] rd_data;
    logic irq;
  } mon_state_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_state_t;

endpackage : lbm_pkg
`default_nettype wire

// >>> include/lbm_tick_if.sv
// Fill-cycle tick carried from the timebase to the monitor
`timescale 1ns/10ps
`default_nettype none
interface lbm_tick_if;
  logic tick;
  modport gen (output tick);
  modport mon (input tick);
endinterface : lbm_tick_if
`default_nettype wire

// >>> hdl/lbm_tick_gen.sv
// Timebase: one-cycle tick at the end of every fill cycle
`timescale 1ns/10ps
`default_nettype none
`include "lbm_map.svh"
module lbm_tick_gen
  import lbm_pkg::*;
#(
  parameter int unsigned FILL_CYCLES = `LBM_FILL_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  lbm_tick_if.gen tk
);

  localparam logic [31:0] LAST = 32'(FILL_CYCLES - 1);

  tick_state_t q;
  tick_state_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt >= LAST) begin
      d.cnt = 32'h0000_0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '{cnt: 32'h0000_0000, tick: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign tk.tick = q.tick;

  property p_tick_single;
    @(posedge clk_sys) disable iff (!nrst)
      q.tick |=> !q.tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

endmodule : lbm_tick_gen
`default_nettype wire

// >>> hdl/leaky_bucket_activity_monitor.sv
// Leaky-bucket inactivity monitor for one reference input, set 3
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "lbm_map.svh"

// What this block does
// - Judge the input once per 128 ms.
// - Bad fill cycle adds one to accumulator.
// - Clean period of 1/2/4/8 cycles subtracts one.
// - Alarm clears when accumulator falls to lower level.
// - Lower level held in a software register.
// - Accumulator never climbs past bucket size.
// - Bucket size reads back last value written.
// - Alarm raised when accumulator reaches upper level.
// - Decay codes 128/256/512/1024 ms, reset code 01.
module leaky_bucket_activity_monitor
  import lbm_pkg::*;
#(
  parameter int unsigned FILL_CYCLES = `LBM_FILL_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ref_failed,
  input wire logic ref_erratic,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic inactivity_alarm,
  output logic irq
);

  localparam mon_state_t ST_RST = '{
    fail_s1: 1'b0,
    fail_s2: 1'b0,
    err_s1: 1'b0,
    err_s2: 1'b0,
    bad_seen: 1'b0,
    acc: 8'h00,
    clean: 3'h0,
    alarm: ALARM_IDLE,
    size: `LBM_RST_SIZE,
    lower: `LBM_RST_LOWER,
    upper: `LBM_RST_UPPER,
    rate: `LBM_RST_DECAY,
    stat: 2'h0,
    mask: `LBM_RST_MASK,
    rd_data: 8'h00,
    irq: 1'b0
  };

  mon_state_t q;
  mon_state_t d;

  lbm_tick_if u_tick_if ();

  lbm_tick_gen #(
    .FILL_CYCLES(FILL_CYCLES)
  ) u_tick_gen (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tk(u_tick_if.gen)
  );

  logic tick;
  assign tick = u_tick_if.tick;

  function automatic logic reg_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction : reg_hit

  // Last clean-cycle index before one unit leaks out
  function automatic logic [2:0] decay_last(input logic [1:0] rate);
    logic [2:0] last;
    last = 3'h0;
    case (rate)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      2'h3: last = 3'h7;
      default: last = 3'h0;
    endcase
    return last;
  endfunction : decay_last

  function automatic logic [7:0] read_mux(
    input logic [7:0] addr,
    input mon_state_t s
  );
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `LBM_ADDR_UPPER: v = s.upper;
      `LBM_ADDR_LOWER: v = s.lower;
      `LBM_ADDR_SIZE: v = s.size;
      `LBM_ADDR_DECAY: v = {6'h00, s.rate};
      `LBM_ADDR_IRQ_STAT: v = {6'h00, s.stat};
      `LBM_ADDR_IRQ_MASK: v = {6'h00, s.mask};
      `LBM_ADDR_LEVEL: v = s.acc;
      `LBM_ADDR_FLAGS: v = {6'h00, s.bad_seen, s.alarm == ALARM_RAISED};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  logic bad_now;
  logic cycle_bad;
  logic ev_raise;
  logic ev_clear;
  logic [1:0] stat_w1c;

  always_comb begin
    d = q;
    // Pins pass two flops before anything looks at them
    d.fail_s1 = ref_failed;
    d.fail_s2 = q.fail_s1;
    d.err_s1 = ref_erratic;
    d.err_s2 = q.err_s1;
    bad_now = q.fail_s2 | q.err_s2;
    // A fault seen in the tick cycle still counts for the closing cycle
    cycle_bad = q.bad_seen | bad_now;

    if (tick) begin
      d.bad_seen = 1'b0;
      if (cycle_bad) begin
        d.clean = 3'h0;
        if (q.acc < q.size) begin
          d.acc = q.acc + 8'h01;
        end
      end else if (q.clean >= decay_last(q.rate)) begin
        // Compare with >= so a lowered rate cannot strand the counter
        d.clean = 3'h0;
        if (q.acc != 8'h00) begin
          d.acc = q.acc - 8'h01;
        end
      end else begin
        d.clean = q.clean + 3'h1;
      end
      if (d.acc >= q.upper) begin
        d.alarm = ALARM_RAISED;
      end else if (d.acc <= q.lower) begin
        d.alarm = ALARM_IDLE;
      end
      // Between the levels the alarm keeps its state
    end else begin
      d.bad_seen = cycle_bad;
    end

    ev_raise = (q.alarm == ALARM_IDLE) && (d.alarm == ALARM_RAISED);
    ev_clear = (q.alarm == ALARM_RAISED) && (d.alarm == ALARM_IDLE);

    if (reg_hit(reg_wr, reg_addr, `LBM_ADDR_UPPER)) begin
      d.upper = reg_wdata;
    end
    if (reg_hit(reg_wr, reg_addr, `LBM_ADDR_LOWER)) begin
      d.lower = reg_wdata;
    end
    if (reg_hit(reg_wr, reg_addr, `LBM_ADDR_SIZE)) begin
      d.size = reg_wdata;
    end
    if (reg_hit(reg_wr, reg_addr, `LBM_ADDR_DECAY)) begin
      d.rate = reg_wdata[1:0];
    end
    if (reg_hit(reg_wr, reg_addr, `LBM_ADDR_IRQ_MASK)) begin
      d.mask = reg_wdata[1:0];
    end

    // Write one to clear; a fresh event in the same cycle wins
    stat_w1c = reg_hit(reg_wr, reg_addr, `LBM_ADDR_IRQ_STAT) ? reg_wdata[1:0] : 2'h0;
    d.stat = q.stat & ~stat_w1c;
    d.stat[`LBM_IRQ_RAISE] = d.stat[`LBM_IRQ_RAISE] | ev_raise;
    d.stat[`LBM_IRQ_CLEAR] = d.stat[`LBM_IRQ_CLEAR] | ev_clear;
    d.irq = |(d.stat & d.mask);

    // Read data stands only in the cycle after the strobe
    d.rd_data = reg_rd ? read_mux(reg_addr, q) : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rd_data;
  assign inactivity_alarm = (q.alarm == ALARM_RAISED);
  assign irq = q.irq;

  // Helper for the tick spacing check only
  logic [31:0] gap_q;
  logic seen_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gap_q <= 32'h0000_0000;
      seen_q <= 1'b0;
    end else if (tick) begin
      gap_q <= 32'h0000_0000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h0000_0001;
    end
  end

  property p_fill_period;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && seen_q) |-> (gap_q == 32'(FILL_CYCLES - 1));
  endproperty
  a_fill_period: assert property (p_fill_period) else $error("fill tick spacing wrong");

  property p_fill_add;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && cycle_bad && (q.acc < q.size)) |=> (q.acc == $past(q.acc) + 8'h01);
  endproperty
  a_fill_add: assert property (p_fill_add) else $error("bad cycle did not add one");

  property p_leak_fast;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && !cycle_bad && (q.rate == 2'h0) && (q.acc != 8'h00))
      |=> (q.acc == $past(q.acc) - 8'h01);
  endproperty
  a_leak_fast: assert property (p_leak_fast) else $error("no leak at fill rate");

  property p_alarm_clear;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && !reg_wr) ##1 ((q.acc <= q.lower) && (q.acc < q.upper))
      |-> (q.alarm == ALARM_IDLE);
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared at lower level");

  property p_lower_store;
    @(posedge clk_sys) disable iff (!nrst)
      (reg_wr && (reg_addr == `LBM_ADDR_LOWER)) |=> (q.lower == $past(reg_wdata));
  endproperty
  a_lower_store: assert property (p_lower_store) else $error("lower level not stored");

  property p_size_cap;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && cycle_bad && (q.acc >= q.size)) |=> $stable(q.acc);
  endproperty
  a_size_cap: assert property (p_size_cap) else $error("accumulator passed bucket size");

  property p_size_readback;
    @(posedge clk_sys) disable iff (!nrst)
      (reg_wr && (reg_addr == `LBM_ADDR_SIZE))
      ##1 (reg_rd && !reg_wr && (reg_addr == `LBM_ADDR_SIZE))
      |=> (reg_rdata == $past(reg_wdata, 2));
  endproperty
  a_size_readback: assert property (p_size_readback) else $error("bucket size readback wrong");

  property p_alarm_raise;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && !reg_wr) ##1 (q.acc >= q.upper) |-> inactivity_alarm;
  endproperty
  a_alarm_raise: assert property (p_alarm_raise) else $error("alarm not raised at upper level");

  property p_leak_eighth;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && !cycle_bad && (q.rate == 2'h3) && (q.clean < 3'h7)) |=> $stable(q.acc);
  endproperty
  a_leak_eighth: assert property (p_leak_eighth) else $error("leak before eight clean cycles");

  property p_hold_between;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && !reg_wr) ##1 ((q.acc > q.lower) && (q.acc < q.upper))
      |-> (q.alarm == $past(q.alarm));
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("alarm moved inside hysteresis");

  property p_floor;
    @(posedge clk_sys) disable iff (!nrst)
      (tick && !cycle_bad && (q.acc == 8'h00)) |=> (q.acc == 8'h00);
  endproperty
  a_floor: assert property (p_floor) else $error("accumulator went below zero");

  property p_quiet_between;
    @(posedge clk_sys) disable iff (!nrst)
      !tick |=> $stable(q.acc) && $stable(q.alarm);
  endproperty
  a_quiet_between: assert property (p_quiet_between) else $error("bucket moved without tick");

  property p_irq_level;
    @(posedge clk_sys) disable iff (!nrst)
      ##1 1'b1 |-> (irq == |(q.stat & q.mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq disagrees with status and mask");

endmodule : leaky_bucket_activity_monitor
`default_nettype wire

// >>> tb/leaky_bucket_activity_monitor_tb_top.sv
// Self-checking bench for the leaky-bucket activity monitor
`timescale 1ns/10ps
`default_nettype none
`include "lbm_map.svh"
module leaky_bucket_activity_monitor_tb_top;
  import lbm_pkg::*;
  localparam int FC = 16;
  localparam logic [7:0] RST_VAL [8] = '{8'h06, 8'h04, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] KEEP [3] = '{8'hFF, 8'hFF, 8'h03};
  logic clk_sys, nrst, ref_failed, ref_erratic, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v;
  logic inactivity_alarm, irq;
  int errors = 0, total_checks = 0, cyc = 0, seed = 32'h2747, m_clean;
  logic [7:0] m_acc, m_size, m_lower, m_upper;
  logic [1:0] m_rate, m_stat, m_mask;
  logic m_alarm, prev;

  leaky_bucket_activity_monitor #(.FILL_CYCLES(FC)) i_leaky_bucket_activity_monitor (
    .clk_sys(clk_sys), .nrst(nrst), .ref_failed(ref_failed), .ref_erratic(ref_erratic),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .inactivity_alarm(inactivity_alarm), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Mirrors the fill timer so inputs change well clear of each tick
  always @(posedge clk_sys) cyc <= nrst ? cyc + 1 : 0;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Starts at once so a read can follow a write with no gap
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic to_phase(input int p);
    do @(posedge clk_sys); while ((cyc + 1) % FC != p);
  endtask : to_phase

  function automatic void step(input logic bad);
    if (bad) begin
      m_clean = 0;
      if (m_acc < m_size) m_acc++;
    end else if (m_clean >= (1 << m_rate) - 1) begin
      m_clean = 0;
      if (m_acc != 8'h00) m_acc--;
    end else begin
      m_clean++;
    end
    if (m_acc >= m_upper) begin
      if (!m_alarm) m_stat[0] = 1'b1;
      m_alarm = 1'b1;
    end else if (m_acc <= m_lower) begin
      if (m_alarm) m_stat[1] = 1'b1;
      m_alarm = 1'b0;
    end
  endfunction : step

  // One fill cycle; a fault on either pin, held over the tick, marks it bad
  task automatic tick(input logic f);
    logic sel;
    sel = 1'($random(seed));
    to_phase(12);
    ref_failed <= f & sel;
    ref_erratic <= f & ~sel;
    to_phase(1);
    step(f | prev);
    prev = f;
    rd(`LBM_ADDR_LEVEL);
    check(d, m_acc, "accumulator");
    check({7'h00, inactivity_alarm}, {7'h00, m_alarm}, "alarm");
    rd(`LBM_ADDR_IRQ_STAT);
    check(d, {6'h00, m_stat}, "status");
    check({7'h00, irq}, {7'h00, |(m_stat & m_mask)}, "irq");
  endtask : tick

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    m_acc = 8'h00;
    m_clean = 0;
    {m_upper, m_lower, m_size, m_rate} = {8'h06, 8'h04, 8'h08, 2'h1};
    {m_stat, m_mask, m_alarm, prev} = '0;
  endtask : do_reset

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  initial begin
    {nrst, ref_failed, ref_erratic, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    do_reset();
    for (int i = 0; i < 8; i++) begin
      rd(8'h5C + i[7:0]);
      check(d, RST_VAL[i], "reset value");
    end
    wr(8'h70, 8'hA5);
    rd(8'h70);
    check(d, 8'h00, "unmapped");
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      wr(8'(`LBM_ADDR_LOWER + i % 3), v);
      rd(8'(`LBM_ADDR_LOWER + i % 3));
      check(d, v & KEEP[i % 3], "readback");
    end
    $display("register test done");
    do_reset();
    // Upper level sits below the bucket size so saturation is seen with the alarm up
    wr(`LBM_ADDR_UPPER, 8'h05);
    wr(`LBM_ADDR_LOWER, 8'h02);
    wr(`LBM_ADDR_SIZE, 8'h06);
    wr(`LBM_ADDR_DECAY, 8'h00);
    {m_upper, m_lower, m_size, m_rate} = {8'h05, 8'h02, 8'h06, 2'h0};
    repeat (9) tick(1'b1);
    wr(`LBM_ADDR_IRQ_MASK, 8'h03);
    m_mask = 2'h3;
    tick(1'b1);
    wr(`LBM_ADDR_IRQ_STAT, 8'h01);
    m_stat[0] = 1'b0;
    repeat (9) tick(1'b0);
    $display("fill and drain test done");
    for (int r = 1; r < 4; r++) begin
      wr(`LBM_ADDR_DECAY, r[7:0]);
      m_rate = r[1:0];
      repeat (4) tick(1'b1);
      repeat (20) tick(1'b0);
    end
    $display("decay rate test done");
    repeat (60) begin
      tick($random(seed) % 2 == 0);
      v = 8'($random(seed));
      wr(`LBM_ADDR_DECAY, v);
      m_rate = v[1:0];
      wr(`LBM_ADDR_IRQ_STAT, v);
      m_stat = m_stat & ~v[1:0];
    end
    $display("random test done");
    results();
  end

  initial begin
    repeat (6000) @(posedge clk_sys);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule : leaky_bucket_activity_monitor_tb_top
`default_nettype wire
